// *** tb_user_break_chd_and_pc_trace.sv ***
// Purpose: Self-checking bench of break control bits and branch trace
// Assumes: APB answer within a bounded wait
// Notes: Break pulses are counted, not sampled once
module tb_user_break_chd_and_pc_trace import ubtr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals and instances
    logic CLK_I = 0, RESET_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
    logic [AW-1:0] PADDR_I = '0;
    logic [DW-1:0] PWDATA_I = '0, PRDATA_O, BRANCH_SRC_I, TARGET_ADDR_I, rd;
    logic [PID_W-1:0] BRANCH_PID_I;
    logic PREADY_O, PSLVERR_O, CHD_BREAK_O, IRQ_O, er, CHD_ADDR_MATCH_I, CHD_DATA_MATCH_I;
    logic CHD_IS_FETCH_I, CHD_IS_DMA_I, INSN_ISSUE_I, INSN_RETIRE_I, FETCH_FLUSH_I;
    logic BRANCH_I, TARGET_FETCH_I;
    int n_fail = 0, n_checks = 0, n_brk = 0, b;
    ubtr_top i_dut (.*);
    ubtr_cpu_model m (.clk_i(CLK_I), .match_o(CHD_ADDR_MATCH_I), .dmatch_o(CHD_DATA_MATCH_I),
        .fetch_o(CHD_IS_FETCH_I), .dma_o(CHD_IS_DMA_I), .issue_o(INSN_ISSUE_I),
        .retire_o(INSN_RETIRE_I), .flush_o(FETCH_FLUSH_I), .branch_o(BRANCH_I),
        .src_o(BRANCH_SRC_I), .pid_o(BRANCH_PID_I), .tfetch_o(TARGET_FETCH_I),
        .taddr_o(TARGET_ADDR_I));
    initial begin
        forever #5 CLK_I = ~CLK_I;
    end
    // Counting catches a pulse however late it lands
    always @(posedge CLK_I) begin
        if (CHD_BREAK_O === 1'b1) n_brk <= n_brk + 1;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input string w, input logic [DW-1:0] e, input logic [DW-1:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int i;
        @(posedge CLK_I);
        {PSEL_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'b1, w, a, d};
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        i = 0;
        do begin
            @(posedge CLK_I);
            i++;
        end while (PREADY_O !== 1'b1 && i < 20);
        {rd, er} = {PRDATA_O, PSLVERR_O};
        {PSEL_I, PENABLE_I} <= 2'b00;
        if (i >= 20) begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
        apb(1'b0, a, '0);
        cmp("read", e, rd);
    endtask
    task automatic brk(input int e);
        repeat (3) @(posedge CLK_I);
        cmp("breaks", e, n_brk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_ctrl();
        rdc(A_BRK_CTRL, 32'h0);
        apb(1'b0, 8'h10, '0);
        cmp("flags", 32'h0, rd & 32'h0000_8080);
        apb(1'b1, A_BRK_CTRL, 32'hffff_ffec);
        rdc(A_BRK_CTRL, 32'h0000_002c);
        $display("test ctrl done");
    endtask
    task automatic t_dma();
        apb(1'b1, A_BRK_CTRL, 32'h0);
        apb(1'b1, A_IRQ_MASK, 32'h2);
        b = n_brk;
        m.hit(1'b1, 1'b0, 1'b1);
        brk(b + 1);
        cmp("irq", 32'h1, {31'h0, IRQ_O});
        apb(1'b1, A_IRQ_STAT, 32'h2);
        rdc(A_BRK_CTRL, 32'h0000_0040);
        apb(1'b1, A_BRK_CTRL, 32'h0);
        rdc(A_BRK_CTRL, 32'h0);
        $display("test dma done");
    endtask
    task automatic t_cond();
        apb(1'b1, A_EXEC_CNT, 32'h2);
        apb(1'b1, A_BRK_CTRL, 32'h20);
        b = n_brk;
        m.hit(1'b0, 1'b0, 1'b1);
        brk(b);
        m.hit(1'b0, 1'b0, 1'b1);
        brk(b + 1);
        apb(1'b1, A_BRK_CTRL, 32'h08);
        m.hit(1'b0, 1'b0, 1'b0);
        brk(b + 1);
        m.hit(1'b0, 1'b0, 1'b1);
        brk(b + 2);
        apb(1'b1, A_BRK_CTRL, 32'h0);
        m.hit(1'b0, 1'b1, 1'b0);
        brk(b + 2);
        m.pulse(0);
        brk(b + 3);
        rdc(A_BRK_CTRL, 32'h0000_0080);
        apb(1'b1, A_BRK_CTRL, 32'h04);
        m.hit(1'b0, 1'b1, 1'b0);
        m.pulse(0);
        brk(b + 3);
        m.pulse(1);
        brk(b + 4);
        apb(1'b1, A_BRK_CTRL, 32'h0);
        m.hit(1'b0, 1'b1, 1'b0);
        m.pulse(2);
        m.pulse(0);
        brk(b + 4);
        $display("test cond done");
    endtask
    task automatic t_trace();
        m.branch(32'h1234_5678, 3'h5);
        m.tgt(32'h0000_a000);
        rdc(8'h10, 32'h0000_d080);
        rdc(8'h20, 32'h1234_5678);
        rdc(8'h10, 32'h0000_5080);
        rdc(8'h30, 32'h0000_a000);
        rdc(8'h10, 32'h0000_5000);
        m.branch(32'h0000_1111, 3'h2);
        m.tgt(32'h0000_b000);
        rdc(8'h24, 32'h1234_5678);
        rdc(8'h34, 32'h0000_a000);
        rdc(8'h14, 32'h0000_5000);
        apb(1'b1, 8'h20, 32'h0);
        cmp("slverr", 32'h1, {31'h0, er});
        $display("test trace done");
    endtask
    initial begin
        repeat (20) @(posedge CLK_I);
        RESET_I <= 1'b0;
        t_ctrl();
        t_dma();
        t_cond();
        t_trace();
        stop_test();
    end
endmodule

// *** ubtr_chd.sv ***
// Purpose: Channel D match qualification, timing and execution count
// Assumes: Match inputs come from same-clock comparator logic
// Notes: A target count of zero fires only on the 4096th occurrence while counting is on
module ubtr_chd import ubtr_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic exec_en_i,
    input wire logic data_en_i,
    input wire logic fetch_after_i,
    input wire logic [CNT_W-1:0] exec_target_i,
    input wire logic addr_match_i,
    input wire logic data_match_i,
    input wire logic is_fetch_i,
    input wire logic is_dma_i,
    input wire logic insn_issue_i,
    input wire logic insn_retire_i,
    input wire logic flush_i,
    output logic brk_cpu_o,
    output logic brk_dma_o
);
    logic pend_q, issued_q, brk_cpu_q, brk_dma_q;
    logic [CNT_W-1:0] cnt_q;
    // Data compare is ignored on fetch cycles
    wire data_ok = is_fetch_i | ~data_en_i | data_match_i;
    wire access_hit = addr_match_i & ~is_fetch_i & data_ok;
    wire fetch_hit = addr_match_i & is_fetch_i;
    // Before: fire at issue; after: fire at retire
    wire fetch_fire = fetch_after_i ? (issued_q & insn_retire_i)
                                    : (pend_q & insn_issue_i);
    wire occur = access_hit | fetch_fire;
    wire [CNT_W-1:0] cnt_inc = cnt_q + 1'b1;
    wire count_done = cnt_inc == exec_target_i;
    wire fire = occur & (~exec_en_i | count_done);
    // ==========================================================
    // Fetch tracking; a flush cancels a pending fetch that is not issued in that cycle and any fetch matched in that cycle
    always_ff @(posedge clk_i) begin
        if (rst_i | flush_i) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= fetch_hit | (pend_q & ~insn_issue_i);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            issued_q <= 1'b0;
        end else begin
            issued_q <= (pend_q & insn_issue_i & fetch_after_i) | (issued_q & ~insn_retire_i);
        end
    end
    // Occurrence counter restarts after each counted break
    always_ff @(posedge clk_i) begin
        if (rst_i | ~exec_en_i) begin
            cnt_q <= CNT_RST;
        end else if (occur) begin
            cnt_q <= count_done ? CNT_RST : cnt_inc;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brk_cpu_q <= 1'b0;
            brk_dma_q <= 1'b0;
        end else begin
            // A fetch break is always a CPU event, whatever the DMA qualifier shows
            brk_cpu_q <= fire & (fetch_fire | ~is_dma_i);
            brk_dma_q <= fire & ~fetch_fire & is_dma_i;
        end
    end
    assign brk_cpu_o = brk_cpu_q;
    assign brk_dma_o = brk_dma_q;
    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_fetch_before;
        pend_q && insn_issue_i && !flush_i && !fetch_after_i && !exec_en_i;
    endsequence
    before_break_a: assert property (s_fetch_before |=> brk_cpu_o)
        else $error("Pre-execution break missing");
    data_gate_a: assert property (addr_match_i && !is_fetch_i && data_en_i && !data_match_i
        && !fetch_fire |=> !brk_cpu_o && !brk_dma_o)
        else $error("Break despite data mismatch");
    count_gate_a: assert property (exec_en_i && occur && !count_done
        |=> !brk_cpu_o && !brk_dma_o)
        else $error("Break before execution count reached");
endmodule

// *** ubtr_cpu_model.sv ***
// Purpose: Far-side model of CPU pipeline and DMA bus observers
// Assumes: Driven by bench tasks, one clock
// Notes: Address lines show inverted data once released
module ubtr_cpu_model import ubtr_pkg::*; (
    input wire logic clk_i,
    output logic match_o,
    output logic dmatch_o,
    output logic fetch_o,
    output logic dma_o,
    output logic issue_o,
    output logic retire_o,
    output logic flush_o,
    output logic branch_o,
    output logic [DW-1:0] src_o,
    output logic [PID_W-1:0] pid_o,
    output logic tfetch_o,
    output logic [DW-1:0] taddr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Cycle pulses
    initial begin
        {match_o, dmatch_o, fetch_o, dma_o, issue_o, retire_o} = '0;
        {flush_o, branch_o, tfetch_o, pid_o} = '0;
        src_o = '1;
        taddr_o = '1;
    end
    // One matched bus cycle, qualifiers inverted after it
    task automatic hit(input logic dma, input logic fet, input logic dm);
        @(posedge clk_i);
        {match_o, dma_o, fetch_o, dmatch_o} <= {1'b1, dma, fet, dm};
        @(posedge clk_i);
        {match_o, dma_o, fetch_o, dmatch_o} <= {1'b0, ~dma, ~fet, ~dm};
    endtask
    // One pipeline pulse: 0 issue, 1 retire, 2 flush
    task automatic pulse(input int k);
        @(posedge clk_i);
        {issue_o, retire_o, flush_o} <= 3'b100 >> k;
        @(posedge clk_i);
        {issue_o, retire_o, flush_o} <= 3'b000;
    endtask
    // Branch comes before its target fetch
    task automatic branch(input logic [DW-1:0] s, input logic [PID_W-1:0] p);
        @(posedge clk_i);
        {branch_o, src_o, pid_o} <= {1'b1, s, p};
        @(posedge clk_i);
        {branch_o, src_o, pid_o} <= {1'b0, ~s, ~p};
    endtask
    task automatic tgt(input logic [DW-1:0] a);
        @(posedge clk_i);
        {tfetch_o, taddr_o} <= {1'b1, a};
        @(posedge clk_i);
        {tfetch_o, taddr_o} <= {1'b0, ~a};
    endtask
endmodule

// *** ubtr_fifo.sv ***
// Purpose: Four-deep branch trace queue of flags, source and target
// Assumes: Strobes come from logic on the same clock
// Notes: Address and pointer storage has no reset on purpose
module ubtr_fifo import ubtr_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    ubtr_trace_if.store tr
);
    logic [DEPTH-1:0] svf_q;
    logic [DEPTH-1:0] dvf_q;
    logic [PID_W-1:0] pid_q [DEPTH];
    logic [DW-1:0] src_q [DEPTH];
    logic [DW-1:0] dst_q [DEPTH];
    // ==========================================================
    // Entries; a read clear follows its entry when the queue shifts
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        logic svf_in, dvf_in;
        if (i == 0) begin : g_head
            assign svf_in = 1'b0;
            assign dvf_in = 1'b0;
        end else begin : g_body
            assign svf_in = svf_q[i-1] & ~tr.clr_src[i-1];
            assign dvf_in = dvf_q[i-1] & ~tr.clr_tgt[i-1];
        end
        // Valid flags; a target fetch beats a read clear
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                svf_q[i] <= 1'b0;
                dvf_q[i] <= 1'b0;
            end else if (tr.shift) begin
                svf_q[i] <= (i == 0) ? tr.tgt_set : svf_in;
                dvf_q[i] <= (i == 0) ? tr.tgt_set : dvf_in;
            end else begin
                svf_q[i] <= ((i == 0) & tr.tgt_set) | (svf_q[i] & ~tr.clr_src[i]);
                dvf_q[i] <= ((i == 0) & tr.tgt_set) | (dvf_q[i] & ~tr.clr_tgt[i]);
            end
        end
        // Payload without reset; all three queues move together
        always_ff @(posedge clk_i) begin
            if (tr.shift) begin
                pid_q[i] <= (i == 0) ? tr.ibuf_pointer : pid_q[(i == 0) ? 0 : i-1];
                src_q[i] <= (i == 0) ? tr.src : src_q[(i == 0) ? 0 : i-1];
                dst_q[i] <= (i == 0) ? tr.dst : dst_q[(i == 0) ? 0 : i-1];
            end else if ((i == 0) && tr.tgt_set) begin
                dst_q[i] <= tr.dst;
            end
        end
        assign tr.pid_e[i] = pid_q[i];
        assign tr.src_e[i] = src_q[i];
        assign tr.dst_e[i] = dst_q[i];
    end
    assign tr.source_valid_flag = svf_q;
    assign tr.target_valid_flag = dvf_q;
    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    shift_moves_src_a: assert property (tr.shift |=> src_q[1] == $past(src_q[0]))
        else $error("Source queue did not shift");
    queues_aligned_a: assert property (tr.shift |=> dst_q[1] == $past(dst_q[0])
        && pid_q[1] == $past(pid_q[0]))
        else $error("Target or pointer queue out of step");
    target_sets_valid_a: assert property (tr.tgt_set |=> svf_q[0] && dvf_q[0])
        else $error("Target fetch did not set valid flags");
    read_clears_svf_a: assert property (tr.clr_src[1] && !tr.shift |=> !svf_q[1])
        else $error("Source read did not clear flag");
    reset_clears_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> svf_q == '0 && dvf_q == '0)
        else $error("Reset left a valid flag set");
endmodule

// *** ubtr_pkg.sv ***
// Purpose: Shared constants and types of the user break trace block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: All offsets are byte addresses
package ubtr_pkg;
    // ==========================================================
    // Bus and register map
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    localparam logic [AW-1:0] A_BRK_CTRL = 8'h00;
    localparam logic [AW-1:0] A_EXEC_CNT = 8'h04;
    localparam logic [AW-1:0] A_IRQ_STAT = 8'h08;
    localparam logic [AW-1:0] A_IRQ_MASK = 8'h0c;
    localparam logic [3:0] G_FLAGS = 4'h1;
    localparam logic [3:0] G_SRC = 4'h2;
    localparam logic [3:0] G_TGT = 4'h3;
    localparam int unsigned GRP_LSB = 4;
    localparam int unsigned IDX_LSB = 2;
    // ==========================================================
    // Break control fields (channel D)
    localparam int unsigned BC_CPU_FLAG = 7;
    localparam int unsigned BC_DMA_FLAG = 6;
    localparam int unsigned BC_EXEC_EN = 5;
    localparam int unsigned BC_DATA_EN = 3;
    localparam int unsigned BC_FETCH_AFTER = 2;
    localparam logic BC_RST = 1'b0;
    localparam int unsigned CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
    // ==========================================================
    // Trace flag fields
    localparam int unsigned DEPTH = 4;
    localparam int unsigned IDX_W = 2;
    localparam int unsigned BF_SVF = 15;
    localparam int unsigned BF_PID_LSB = 12;
    localparam int unsigned BF_DVF = 7;
    localparam int unsigned PID_W = 3;
    // ==========================================================
    // Interrupt status bits
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_CPU = 0;
    localparam int unsigned IRQ_DMA = 1;
    localparam int unsigned IRQ_TRACE = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
    // APB slave states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_ANSWER = 1'b1
    } ubtr_apb_t;
endpackage

// *** ubtr_top.sv ***
// Purpose: Channel D break control bits and branch trace, APB reachable
// Assumes: CPU and DMA observers run on CLK_I; APB master per AMBA APB
// Notes: Trace payload is never reset; only valid flags are
//
// Chosen here: the address map and the APB register port.
module ubtr_top import ubtr_pkg::*; (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [AW-1:0] PADDR_I,
    input wire logic [DW-1:0] PWDATA_I,
    output logic [DW-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic CHD_ADDR_MATCH_I,
    input wire logic CHD_DATA_MATCH_I,
    input wire logic CHD_IS_FETCH_I,
    input wire logic CHD_IS_DMA_I,
    input wire logic INSN_ISSUE_I,
    input wire logic INSN_RETIRE_I,
    input wire logic FETCH_FLUSH_I,
    input wire logic BRANCH_I,
    input wire logic [DW-1:0] BRANCH_SRC_I,
    input wire logic [PID_W-1:0] BRANCH_PID_I,
    input wire logic TARGET_FETCH_I,
    input wire logic [DW-1:0] TARGET_ADDR_I,
    output logic CHD_BREAK_O,
    output logic IRQ_O
);
    // ==========================================================
    // APB slave state
    ubtr_apb_t st_q, st_d;
    logic pready_q, pslverr_q;
    logic [DW-1:0] prdata_q;
    // Control and status registers
    logic cpu_flag_q, dma_flag_q, exec_en_q, data_en_q, fetch_after_q;
    logic [CNT_W-1:0] exec_cnt_q;
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
    logic irq_q, brk_q;
    logic brk_cpu, brk_dma;
    logic [DW-1:0] rdata;
    ubtr_trace_if tr ();

    // ==========================================================
    // Address decode
    wire access = PSEL_I & PENABLE_I;
    wire done = access & pready_q;
    wire wr_done = done & PWRITE_I;
    wire rd_done = done & ~PWRITE_I;
    wire aligned = PADDR_I[IDX_LSB-1:0] == '0;
    wire [3:0] grp = PADDR_I[GRP_LSB +: 4];
    wire [IDX_W-1:0] idx = PADDR_I[IDX_LSB +: IDX_W];
    wire hit_bc = PADDR_I == A_BRK_CTRL;
    wire hit_cnt = PADDR_I == A_EXEC_CNT;
    wire hit_stat = PADDR_I == A_IRQ_STAT;
    wire hit_mask = PADDR_I == A_IRQ_MASK;
    wire hit_flags = aligned & (grp == G_FLAGS);
    wire hit_src = aligned & (grp == G_SRC);
    wire hit_tgt = aligned & (grp == G_TGT);
    wire hit_rw = hit_bc | hit_cnt | hit_stat | hit_mask;
    wire hit_ro = hit_flags | hit_src | hit_tgt;
    // Trace registers are read-only, so a write there is refused
    wire bad = ~(hit_rw | (hit_ro & ~PWRITE_I));
    wire wr_bc = wr_done & hit_bc & ~pslverr_q;
    wire wr_cnt = wr_done & hit_cnt;
    wire wr_stat = wr_done & hit_stat;
    wire wr_mask = wr_done & hit_mask;

    // ==========================================================
    // Answer one cycle into the access phase, then drop ready
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (access) begin
                    st_d = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            st_q <= ST_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pready_q <= st_d == ST_ANSWER;
            pslverr_q <= (st_d == ST_ANSWER) & bad;
        end
    end

    // Read data is latched with ready, so it stands through the answer
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            prdata_q <= '0;
        end else if (st_q == ST_IDLE && access) begin
            prdata_q <= bad ? '0 : rdata;
        end
    end

    // ==========================================================
    // Read multiplexer; unused and reserved bits stay zero
    always_comb begin
        rdata = '0;
        if (hit_bc) begin
            rdata[BC_CPU_FLAG] = cpu_flag_q;
            rdata[BC_DMA_FLAG] = dma_flag_q;
            rdata[BC_EXEC_EN] = exec_en_q;
            rdata[BC_DATA_EN] = data_en_q;
            rdata[BC_FETCH_AFTER] = fetch_after_q;
        end else if (hit_cnt) begin
            rdata[CNT_W-1:0] = exec_cnt_q;
        end else if (hit_stat) begin
            rdata[IRQ_W-1:0] = irq_stat_q;
        end else if (hit_mask) begin
            rdata[IRQ_W-1:0] = irq_mask_q;
        end else if (hit_flags) begin
            rdata[BF_SVF] = tr.source_valid_flag[idx];
            rdata[BF_PID_LSB +: PID_W] = tr.pid_e[idx];
            rdata[BF_DVF] = tr.target_valid_flag[idx];
        end else if (hit_src) begin
            rdata = tr.src_e[idx];
        end else if (hit_tgt) begin
            rdata = tr.dst_e[idx];
        end
    end

    // ==========================================================
    // Match flags: hardware sets, a written zero clears, set wins
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            cpu_flag_q <= BC_RST;
            dma_flag_q <= BC_RST;
        end else begin
            cpu_flag_q <= brk_cpu | (cpu_flag_q & ~(wr_bc & ~PWDATA_I[BC_CPU_FLAG]));
            dma_flag_q <= brk_dma | (dma_flag_q & ~(wr_bc & ~PWDATA_I[BC_DMA_FLAG]));
        end
    end

    // Control bits steer the channel D matcher
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            exec_en_q <= BC_RST;
            data_en_q <= BC_RST;
            fetch_after_q <= BC_RST;
        end else if (wr_bc) begin
            exec_en_q <= PWDATA_I[BC_EXEC_EN];
            data_en_q <= PWDATA_I[BC_DATA_EN];
            fetch_after_q <= PWDATA_I[BC_FETCH_AFTER];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            exec_cnt_q <= CNT_RST;
        end else if (wr_cnt) begin
            exec_cnt_q <= PWDATA_I[CNT_W-1:0];
        end
    end

    // ==========================================================
    // Interrupt status: events set, write one clears, set wins
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_stat) begin
            irq_stat_d = irq_stat_q & ~PWDATA_I[IRQ_W-1:0];
        end
        irq_stat_d[IRQ_CPU] = irq_stat_d[IRQ_CPU] | brk_cpu;
        irq_stat_d[IRQ_DMA] = irq_stat_d[IRQ_DMA] | brk_dma;
        irq_stat_d[IRQ_TRACE] = irq_stat_d[IRQ_TRACE] | TARGET_FETCH_I;
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            irq_stat_q <= IRQ_RST;
            irq_mask_q <= IRQ_RST;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_mask) begin
                irq_mask_q <= PWDATA_I[IRQ_W-1:0];
            end
        end
    end

    // Registered so the line is glitch free; lags status by one cycle
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            irq_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
            brk_q <= brk_cpu | brk_dma;
        end
    end

    // ==========================================================
    // Trace capture and read side effects
    assign tr.shift = BRANCH_I;
    assign tr.src = BRANCH_SRC_I;
    assign tr.ibuf_pointer = BRANCH_PID_I;
    assign tr.tgt_set = TARGET_FETCH_I;
    assign tr.dst = TARGET_ADDR_I;
    for (genvar i = 0; i < DEPTH; i++) begin : g_clr
        assign tr.clr_src[i] = rd_done & hit_src & (idx == IDX_W'(i));
        assign tr.clr_tgt[i] = rd_done & hit_tgt & (idx == IDX_W'(i));
    end

    ubtr_fifo u_fifo (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .tr(tr.store)
    );

    ubtr_chd u_chd (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .exec_en_i(exec_en_q),
        .data_en_i(data_en_q),
        .fetch_after_i(fetch_after_q),
        .exec_target_i(exec_cnt_q),
        .addr_match_i(CHD_ADDR_MATCH_I),
        .data_match_i(CHD_DATA_MATCH_I),
        .is_fetch_i(CHD_IS_FETCH_I),
        .is_dma_i(CHD_IS_DMA_I),
        .insn_issue_i(INSN_ISSUE_I),
        .insn_retire_i(INSN_RETIRE_I),
        .flush_i(FETCH_FLUSH_I),
        .brk_cpu_o(brk_cpu),
        .brk_dma_o(brk_dma)
    );

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign CHD_BREAK_O = brk_q;
    assign IRQ_O = irq_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_first_access;
        access && !pready_q;
    endsequence
    sequence s_answer;
        pready_q ##1 !pready_q;
    endsequence
    apb_answer_a: assert property (s_first_access |=> s_answer)
        else $error("Ready not exactly one cycle after access");
    dma_flag_set_a: assert property (brk_dma |=> dma_flag_q)
        else $error("DMA match flag not set");
    flag_sticky_a: assert property ($fell(cpu_flag_q) |-> $past(wr_bc)
        && !$past(PWDATA_I[BC_CPU_FLAG]))
        else $error("Match flag cleared without write");
    bc_reserved_a: assert property (pready_q && hit_bc |-> PRDATA_O[4] == 1'b0
        && PRDATA_O[1:0] == 2'b00)
        else $error("Reserved control bit read as one");
    flags_reserved_a: assert property (pready_q && hit_flags && !pslverr_q
        |-> PRDATA_O[11:8] == 4'h0 && PRDATA_O[6:0] == 7'h00)
        else $error("Reserved flag bit read as one");
    irq_level_a: assert property (##1 IRQ_O == $past(|(irq_stat_q & irq_mask_q)))
        else $error("Interrupt line out of step with status");
endmodule

// *** ubtr_trace_if.sv ***
// Purpose: Carrier between the register logic and the trace store
// Assumes: Single clock domain
// Notes: ctrl drives capture and clear strobes, store returns entries
interface ubtr_trace_if;
    import ubtr_pkg::*;
    logic shift;
    logic [DW-1:0] src;
    logic [PID_W-1:0] ibuf_pointer;
    logic tgt_set;
    logic [DW-1:0] dst;
    logic [DEPTH-1:0] clr_src;
    logic [DEPTH-1:0] clr_tgt;
    logic [DEPTH-1:0] source_valid_flag;
    logic [DEPTH-1:0] target_valid_flag;
    logic [PID_W-1:0] pid_e [DEPTH];
    logic [DW-1:0] src_e [DEPTH];
    logic [DW-1:0] dst_e [DEPTH];
    modport ctrl (output shift, src, ibuf_pointer, tgt_set, dst, clr_src, clr_tgt,
        input source_valid_flag, target_valid_flag, pid_e, src_e, dst_e);
    modport store (input shift, src, ibuf_pointer, tgt_set, dst, clr_src, clr_tgt,
        output source_valid_flag, target_valid_flag, pid_e, src_e, dst_e);
endinterface
